// ===== ripd_top.sv
`timescale 1ns/1ns
module ripd_top
  import ripd_pkg::*;
#(
  parameter int CW = 16,
  parameter int AW = 24
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        pwm_out_pin,
  input  wire logic        shunt_cmp_pin,
  input  wire logic        bemf_cmp_pin,
  output logic             drive_en,
  output logic      [2:0]  drive_dir,
  output logic             zc_valid,
  output logic             zc_cmp_mode,
  output logic             irq
);
  typedef struct packed {
    ripd_state_e         st;
    ripd_phase_e         ph;
    logic [2:0]          k;
    logic [2:0]          dir;
    logic [7:0]          iter;
    logic [7:0]          siter;
    logic [5:0][AW-1:0]  acc;
    logic [AW-1:0]       rev;
    logic [CW-1:0]       cnt;
    logic [CW-1:0]       cap;
    logic [2:0]          sel;
    logic                big;
    logic [2:0]          axis;
    logic [15:0]         rest;
    logic [AW-1:0]       sal_thr;
    logic [AW-1:0]       sat_thr;
    logic [7:0]          sal_max;
    logic [7:0]          sat_max;
    logic [15:0]         speed;
    logic [15:0]         win_dly;
    logic [15:0]         win_len;
    logic [2:0]          mask;
    logic [2:0]          stat;
    logic                busy;
    logic                done;
    logic                fail;
    logic                err;
    logic                salient;
    logic [2:0]          result;
    logic                drive;
    logic [2:0]          prev;
    logic [31:0]         rdata;
  } ripd_top_s;

  ripd_top_s       q;
  ripd_top_s       n;
  logic [2:0]      pin_s;
  logic            pwm_edge;
  logic            cmp_edge;
  logic            mode_chg;
  logic [5:0]      use_m;
  logic [AW-1:0]   mx;
  logic [AW-1:0]   mn;
  logic [2:0]      imx;
  logic [2:0]      imn;
  logic [AW+1:0]   sum3;
  logic [AW-1:0]   diff;
  logic [AW-1:0]   med;
  logic [AW+1:0]   other;
  logic [AW+1:0]   two_rev;
  logic            rev_ok;

  initial begin
    if (CW < 4 || AW < CW + 8 || AW > 30)
      $error("ripd_top: counter or accumulator width not served");
  end

  // direction 0..2 is u-v, v-w, w-u; adding 3 reverses it
  function automatic logic [2:0] rev_dir(input logic [2:0] d);
    rev_dir = (d < 3'd3) ? d + 3'd3 : d - 3'd3;
  endfunction

  // pulse direction for the k-th step of each phase of the search
  function automatic logic [2:0] dir_of(input ripd_phase_e ph,
                                        input logic [2:0] k,
                                        input logic [2:0] axis,
                                        input logic [2:0] sel);
    case (ph)
      P_REV:   dir_of = rev_dir(sel);
      P_POL:   dir_of = (k == 3'd0) ? axis : rev_dir(axis);
      default: dir_of = k;
    endcase
  endfunction

  // number of pulses in one round of each phase
  function automatic logic [2:0] steps(input ripd_phase_e ph);
    case (ph)
      P_SAL:   steps = 3'd3;
      P_REV:   steps = 3'd1;
      P_POL:   steps = 3'd2;
      default: steps = 3'd6;
    endcase
  endfunction

  // pins are asynchronous to clk, so each passes two flops
  ripd_sync2 #(
    .W (3)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({bemf_cmp_pin, shunt_cmp_pin, pwm_out_pin}),
    .q      (pin_s)
  );

  assign pwm_edge = pin_s[0] && !q.prev[0];
  assign cmp_edge = pin_s[1] && !q.prev[1];

  ripd_zc_sel u_zc (
    .clk       (clk),
    .arst_n    (arst_n),
    .pwm_rise  (pwm_edge),
    .bemf_lvl  (pin_s[2]),
    .speed_rpm (q.speed),
    .win_dly   (q.win_dly),
    .win_len   (q.win_len),
    .cmp_mode  (zc_cmp_mode),
    .mode_chg  (mode_chg),
    .zc_valid  (zc_valid)
  );

  // which accumulators take part in the current comparison
  always_comb begin
    case (q.ph)
      P_SAT:   use_m = 6'h3f;
      P_POL:   use_m = 6'(1 << q.axis) | 6'(1 << rev_dir(q.axis));
      default: use_m = 6'h07;
    endcase
  end

  // spread of the accumulated rise times
  always_comb begin
    mx   = '0;
    mn   = '1;
    imx  = 3'd0;
    imn  = 3'd0;
    sum3 = '0;
    for (int i = 0; i < 6; i++) begin
      if (use_m[i] && q.acc[i] >= mx) begin
        mx  = q.acc[i];
        imx = 3'(i);
      end
      if (use_m[i] && q.acc[i] < mn) begin
        mn  = q.acc[i];
        imn = 3'(i);
      end
    end
    for (int i = 0; i < 3; i++) begin
      sum3 = sum3 + (AW+2)'(q.acc[i]);
    end
  end

  assign diff    = mx - mn;
  assign med     = AW'(sum3 - (AW+2)'(mx) - (AW+2)'(mn));
  assign other   = sum3 - (AW+2)'(q.acc[q.sel]);
  assign two_rev = {1'b0, q.rev, 1'b0};
  // reversed pulse must sit on the same side of the two-phase mean
  assign rev_ok  = q.big ? (two_rev > other) : (two_rev < other);

  always_comb begin
    n       = q;
    n.prev  = pin_s;
    n.rdata = 32'h0;
    // register writes; limits only change while idle
    if (bus_wr) begin
      case (bus_addr)
        OFF_CTRL: begin
          if (bus_wdata[CTRL_START_BIT] && !q.busy) begin
            n.busy    = 1'b1;
            n.done    = 1'b0;
            n.fail    = 1'b0;
            n.err     = 1'b0;
            n.salient = 1'b0;
            n.acc     = '0;
            n.rev     = '0;
            n.iter    = 8'h00;
            n.ph      = P_SAL;
            n.k       = 3'd0;
            n.dir     = 3'd0;
            n.drive   = 1'b1;
            n.st      = S_WAIT;
          end
        end
        OFF_SAL_THR: if (!q.busy) n.sal_thr = bus_wdata[AW-1:0];
        OFF_SAT_THR: if (!q.busy) n.sat_thr = bus_wdata[AW-1:0];
        OFF_MAX_CNT: begin
          if (!q.busy) begin
            n.sal_max = bus_wdata[7:0];
            n.sat_max = bus_wdata[MAX_SAT_LSB +: 8];
          end
        end
        OFF_IRQ_STAT: n.stat = q.stat & ~bus_wdata[2:0];
        OFF_IRQ_MASK: n.mask = bus_wdata[2:0];
        OFF_SPEED:    n.speed = bus_wdata[15:0];
        OFF_WIN_DLY:  n.win_dly = bus_wdata[15:0];
        OFF_WIN_LEN:  n.win_len = bus_wdata[15:0];
        default: ;
      endcase
    end
    // measurement sequencer
    case (q.st)
      S_WAIT: begin
        if (pwm_edge) begin
          n.cnt = '0;
          n.st  = S_COUNT;
        end
      end
      S_COUNT: begin
        if (cmp_edge) begin
          n.cap   = q.cnt;
          n.drive = 1'b0;
          n.rest  = REST_CYC;
          n.st    = S_REST;
          if (q.ph == P_REV) begin
            n.rev = q.rev + AW'(q.cnt);
          end else begin
            n.acc[q.dir] = q.acc[q.dir] + AW'(q.cnt);
          end
        end else if (&q.cnt) begin
          n.err   = 1'b1;
          n.drive = 1'b0;
          n.busy  = 1'b0;
          n.stat[IRQ_ERR_BIT] = 1'b1;
          n.st    = S_IDLE;
        end else begin
          n.cnt = q.cnt + CW'(1);
        end
      end
      S_REST: begin
        if (q.rest != 16'h0000) begin
          n.rest = q.rest - 16'h0001;
        end else if (q.k + 3'd1 < steps(q.ph)) begin
          n.k     = q.k + 3'd1;
          n.dir   = dir_of(q.ph, q.k + 3'd1, q.axis, q.sel);
          n.drive = 1'b1;
          n.st    = S_WAIT;
        end else begin
          n.iter = q.iter + 8'h01;
          n.st   = S_EVAL;
        end
      end
      S_EVAL: begin
        n.k     = 3'd0;
        n.drive = 1'b1;
        n.st    = S_WAIT;
        case (q.ph)
          P_SAL: begin
            if (diff >= q.sal_thr) begin
              // confirm: pick the extreme on the wider gap
              n.big   = (mx - med) > (med - mn);
              n.sel   = ((mx - med) > (med - mn)) ? imx : imn;
              n.axis  = imn;
              n.siter = q.iter;
              n.iter  = 8'h00;
              n.ph    = P_REV;
              n.dir   = rev_dir(((mx - med) > (med - mn)) ? imx : imn);
            end else if (q.iter >= q.sal_max) begin
              n.acc  = '0;
              n.iter = 8'h00;
              n.ph   = P_SAT;
              n.dir  = 3'd0;
            end else begin
              n.dir = 3'd0;
            end
          end
          P_REV: begin
            // reversed pulse repeats as many rounds as the saliency pass
            if (q.iter < q.siter) begin
              n.dir = rev_dir(q.sel);
            end else if (rev_ok) begin
              n.salient = 1'b1;
              n.acc     = '0;
              n.iter    = 8'h00;
              n.ph      = P_POL;
              n.dir     = q.axis;
            end else begin
              n.acc  = '0;
              n.iter = 8'h00;
              n.ph   = P_SAT;
              n.dir  = 3'd0;
            end
          end
          default: begin
            if (diff > q.sat_thr || q.iter >= q.sat_max) begin
              // shortest rise points at the pole
              n.result = imn;
              n.fail   = !(diff > q.sat_thr);
              n.done   = 1'b1;
              n.busy   = 1'b0;
              n.drive  = 1'b0;
              n.stat[IRQ_DONE_BIT] = 1'b1;
              n.st     = S_IDLE;
            end else begin
              n.dir = dir_of(q.ph, 3'd0, q.axis, q.sel);
            end
          end
        endcase
      end
      // idle keeps drive off, but not over a start taken this cycle
      default: if (!n.busy) n.drive = 1'b0;
    endcase
    // abort stops drive at once
    if (bus_wr && bus_addr == OFF_CTRL && bus_wdata[CTRL_ABORT_BIT]) begin
      n.drive = 1'b0;
      n.busy  = 1'b0;
      n.st    = S_IDLE;
    end
    // zero-crossing method change; a set beats a same-cycle clear
    if (mode_chg) n.stat[IRQ_ZC_BIT] = 1'b1;
    // read data stands in the cycle after the strobe only
    if (bus_rd) begin
      case (bus_addr)
        OFF_SAL_THR:  n.rdata = 32'(q.sal_thr);
        OFF_SAT_THR:  n.rdata = 32'(q.sat_thr);
        OFF_MAX_CNT:  n.rdata = {16'h0000, q.sat_max, q.sal_max};
        OFF_STATUS:   n.rdata = {21'h0, q.result, 2'b00, zc_cmp_mode,
                                 q.salient, q.err, q.fail, q.done, q.busy};
        OFF_IRQ_STAT: n.rdata = {29'h0, q.stat};
        OFF_IRQ_MASK: n.rdata = {29'h0, q.mask};
        OFF_SPEED:    n.rdata = {16'h0000, q.speed};
        OFF_WIN_DLY:  n.rdata = {16'h0000, q.win_dly};
        OFF_WIN_LEN:  n.rdata = {16'h0000, q.win_len};
        OFF_CAPTURE:  n.rdata = 32'(q.cap);
        default:      n.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q         <= '0;
      q.st      <= S_IDLE;
      q.ph      <= P_SAL;
      q.sal_thr <= RST_SAL_THR;
      q.sat_thr <= RST_SAT_THR;
      q.sal_max <= RST_MAX_CNT;
      q.sat_max <= RST_MAX_CNT;
      q.win_dly <= RST_WIN_DLY;
      q.win_len <= RST_WIN_LEN;
    end else begin
      q <= n;
    end
  end

  assign bus_rdata = q.rdata;
  assign drive_en  = q.drive;
  assign drive_dir = q.dir;
  assign irq       = |(q.stat & q.mask);

  a_count_start: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_WAIT && pwm_edge && !bus_wr) |=>
      (q.st == S_COUNT && q.cnt == '0) ##1 (q.cnt == CW'(1) || cmp_edge ||
      q.st != S_COUNT))
    else $error("rise counter not started on pwm edge");
  a_count_capture: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_COUNT && cmp_edge) |=> (q.cap == $past(q.cnt) && !q.drive))
    else $error("rise time not captured on comparator hit");
  a_ovf_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_COUNT && !cmp_edge && (&q.cnt)) |=>
      (q.err && !drive_en && q.st == S_IDLE && q.stat[IRQ_ERR_BIT]))
    else $error("overflow did not stop drive");
  a_sal_dirs: assert property (@(posedge clk) disable iff (!arst_n)
    (q.ph == P_SAL && drive_en) |-> (drive_dir < 3'd3))
    else $error("saliency pulse outside three pair directions");
  a_sal_stop: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_EVAL && q.ph == P_SAL && diff >= q.sal_thr && !bus_wr) |=>
      (q.ph == P_REV && q.dir == rev_dir(q.sel)))
    else $error("saliency rounds not ended at threshold");
  a_sal_giveup: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_EVAL && q.ph == P_SAL && diff < q.sal_thr &&
     q.iter >= q.sal_max && !bus_wr) |=> (q.ph == P_SAT && q.acc == '0))
    else $error("saliency limit did not hand over to saturation");
  a_sat_result: assert property (@(posedge clk) disable iff (!arst_n)
    (q.st == S_EVAL && (q.ph == P_SAT || q.ph == P_POL) &&
     diff > q.sat_thr && !bus_wr) |=>
      (q.done && !q.fail && !drive_en && q.result == $past(imn)))
    else $error("saturation success not reported");
endmodule

// ===== ripd_pkg.sv
// How it works
// - saliency pulses run in three pair directions, u-v, v-w and w-u.
// - the saliency axis is the 60-degree step of least time within 180.
// - the rise-time counter clears and starts on the pwm rising edge.
// - a shunt comparator hit captures the counter as the rise time.
// - saliency rounds stop once max minus min reaches the threshold.
// - if the round limit passes first, saturation detection follows.
// - the larger of max-median and median-min gaps picks max or min.
// - the picked phase is reversed and must keep its relation to the mean.
// - salient polarity compares forward and backward pulses on the axis.
// - non-salient detection pulses six ways and takes the least time.
// - saturation ends past its threshold; at the limit the same test rules.
// - above 1855 rpm the back-emf comparator detects zero crossings.
// - the comparator method falls back only at 1802 rpm or below.
// - a timer window aligned to pwm on-time gates the comparator.
// - a counter overflow during a rise flags an error and stops drive.
package ripd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_SAL_THR  = 8'h04;
  localparam logic [7:0] OFF_SAT_THR  = 8'h08;
  localparam logic [7:0] OFF_MAX_CNT  = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_SPEED    = 8'h1c;
  localparam logic [7:0] OFF_WIN_DLY  = 8'h20;
  localparam logic [7:0] OFF_WIN_LEN  = 8'h24;
  localparam logic [7:0] OFF_CAPTURE  = 8'h28;
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ERR_BIT    = 1;
  localparam int IRQ_ZC_BIT     = 2;
  localparam int MAX_SAT_LSB    = 8;
  localparam int ST_DIR_LSB     = 8;
  // reset values
  localparam logic [23:0] RST_SAL_THR = 24'h000100;
  localparam logic [23:0] RST_SAT_THR = 24'h000080;
  localparam logic [7:0]  RST_MAX_CNT = 8'h08;
  localparam logic [15:0] RST_WIN_DLY = 16'h0010;
  localparam logic [15:0] RST_WIN_LEN = 16'h0100;
  // speed switch points in rpm
  localparam logic [15:0] SPEED_UP_RPM = 16'd1855;
  localparam logic [15:0] SPEED_DN_RPM = 16'd1802;
  // rest between pulses so the phase current decays
  localparam int CLK_MHZ  = 100;
  localparam int REST_US  = 20;
  localparam logic [15:0] REST_CYC = 16'(REST_US * CLK_MHZ);

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT, S_COUNT, S_REST, S_EVAL
  } ripd_state_e;
  typedef enum logic [1:0] {P_SAL, P_REV, P_POL, P_SAT} ripd_phase_e;
endpackage

// ===== ripd_sync2.sv
`timescale 1ns/1ns
module ripd_sync2
  import ripd_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ripd_sync_s;

  ripd_sync_s r_r;
  ripd_sync_s r_nxt;

  initial begin
    if (W < 1) $error("ripd_sync2: width must be at least one");
  end

  // first stage is read by the second stage only
  always_comb begin
    r_nxt.meta = d;
    r_nxt.stab = r_r.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.stab;
endmodule

// ===== ripd_zc_sel.sv
`timescale 1ns/1ns
module ripd_zc_sel
  import ripd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        pwm_rise,
  input  wire logic        bemf_lvl,
  input  wire logic [15:0] speed_rpm,
  input  wire logic [15:0] win_dly,
  input  wire logic [15:0] win_len,
  output logic             cmp_mode,
  output logic             mode_chg,
  output logic             zc_valid
);
  typedef struct packed {
    logic        mode;
    logic        chg;
    logic        run;
    logic [15:0] tick;
    logic        zc;
  } ripd_zc_s;

  ripd_zc_s q;
  ripd_zc_s n;
  logic     win;

  // the window opens win_dly ticks after the pwm edge and stays open for win_len ticks
  assign win = q.run && (q.tick >= win_dly) &&
               ({1'b0, q.tick} < {1'b0, win_dly} + {1'b0, win_len});

  always_comb begin
    n = q;
    n.chg = 1'b0;
    if (!q.mode && speed_rpm > SPEED_UP_RPM) begin
      n.mode = 1'b1;
      n.chg  = 1'b1;
    end else if (q.mode && speed_rpm <= SPEED_DN_RPM) begin
      n.mode = 1'b0;
      n.chg  = 1'b1;
    end
    // window restarts on each pwm on-edge, stops at the end of the count
    if (pwm_rise) begin
      n.run  = 1'b1;
      n.tick = '0;
    end else if (q.run && q.tick != 16'hffff) begin
      n.tick = q.tick + 16'h0001;
    end else begin
      n.run = 1'b0;
    end
    n.zc = q.mode && win && bemf_lvl;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign cmp_mode = q.mode;
  assign mode_chg = q.chg;
  assign zc_valid = q.zc;

  a_zc_up_switch: assert property (@(posedge clk) disable iff (!arst_n)
    (!q.mode && speed_rpm > SPEED_UP_RPM) |=> (q.mode && q.chg))
    else $error("comparator method not taken above upper speed");
  a_zc_hyst_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (q.mode && speed_rpm > SPEED_DN_RPM) |=> q.mode)
    else $error("comparator method dropped above lower speed");
  a_zc_window_gate: assert property (@(posedge clk) disable iff (!arst_n)
    q.zc |-> ($past(win) && $past(q.mode) && $past(bemf_lvl)))
    else $error("zero crossing passed outside the window");
endmodule

// ===== ripd_motor_model.sv
`timescale 1ns/1ns
// inverter, shunt comparator and motor reduced to one rise time per
// drive direction; no hit at all when no_hit is high
module ripd_motor_model (
  input  wire logic        clk,
  input  wire logic        drive_en,
  input  wire logic [2:0]  drive_dir,
  input  wire logic        ext_pwm,
  input  wire logic        no_hit,
  input  wire logic [59:0] rise_tbl,
  output logic             pwm_out_pin,
  output logic             shunt_cmp_pin
);
  logic [15:0] cnt_r;
  logic        on_r;
  logic [9:0]  lim;

  initial begin
    cnt_r = 16'h0000;
    on_r  = 1'b0;
  end
  // timer output rises one cycle after the request; current ramps from it
  always @(posedge clk) begin
    on_r <= drive_en;
    if (!drive_en) begin
      cnt_r <= 16'h0000;
    end else if (on_r && cnt_r != 16'hffff) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // dirs 6 and 7 never occur; guard keeps the slice in range
  assign lim = (drive_dir > 3'd5) ? 10'h3ff : rise_tbl[drive_dir*10 +: 10];
  assign pwm_out_pin = (drive_en & on_r) | ext_pwm;
  // comparator drops with the drive, current decays during rest
  assign shunt_cmp_pin = drive_en & on_r & ~no_hit & (cnt_r >= {6'h00, lim});
endmodule

// ===== ripd_top_bench.sv
`timescale 1ns/1ns
module ripd_top_bench
  import ripd_pkg::*;
;
  logic        clk;
  logic        arst_n;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        pwm_out_pin;
  logic        shunt_cmp_pin;
  logic        bemf_cmp_pin;
  logic        drive_en;
  logic [2:0]  drive_dir;
  logic        zc_valid;
  logic        zc_cmp_mode;
  logic        irq;
  logic        ext_pwm;
  logic        no_hit;
  logic [59:0] rise_tbl;
  logic [59:0] tb;
  logic [31:0] d;
  logic [2:0]  seq[$];
  logic [2:0]  exq[$];
  logic [2:0]  a;
  logic [2:0]  m;
  logic [2:0]  ed;
  logic        p;
  logic        me;
  logic        de_q;
  logic [15:0] s;
  int          num_errors;
  int          cmp_count;
  int          sp[6] = '{1855, 1856, 1900, 1803, 1802, 1856};

  // counter width cut to 10 bits so an overflow comes quickly
  ripd_top #(.CW(10)) dut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .pwm_out_pin(pwm_out_pin),
    .shunt_cmp_pin(shunt_cmp_pin), .bemf_cmp_pin(bemf_cmp_pin),
    .drive_en(drive_en), .drive_dir(drive_dir), .zc_valid(zc_valid),
    .zc_cmp_mode(zc_cmp_mode), .irq(irq));
  ripd_motor_model motor (.clk(clk), .drive_en(drive_en),
    .drive_dir(drive_dir), .ext_pwm(ext_pwm), .no_hit(no_hit),
    .rise_tbl(rise_tbl), .pwm_out_pin(pwm_out_pin),
    .shunt_cmp_pin(shunt_cmp_pin));

  always #5 clk = ~clk;
  // record the direction of every pulse as it starts
  always @(posedge clk) begin
    de_q <= drive_en;
    if (drive_en === 1'b1 && de_q === 1'b0) begin
      seq.push_back(drive_dir);
    end
  end

  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    bus_addr  <= ad;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, lo, hi, input string msg);
    cmp_count++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h", $time, msg, got);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e,
                      input string msg);
    rd(ad);
    chk(d, e, msg);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 20000; i++) begin
      rd(OFF_STATUS);
      if (d[0] === 1'b0) begin
        break;
      end
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // least rise time over all six directions gives the rotor direction
  function automatic logic [2:0] least(input logic [59:0] t);
    logic [2:0] b;
    b = 3'd0;
    for (int k = 1; k < 6; k++) begin
      if (t[k*10 +: 10] < t[b*10 +: 10]) begin
        b = 3'(k);
      end
    end
    return b;
  endfunction

  // a run is some 62k cycles; this leaves ample margin
  initial begin
    #900000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bemf_cmp_pin = 1'b0;
    ext_pwm = 1'b0;
    no_hit = 1'b0;
    rise_tbl = 60'h0;
    de_q = 1'b0;
    me = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h9781));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rchk(OFF_SAL_THR, {8'h00, RST_SAL_THR}, "sal thr");
    rchk(OFF_SAT_THR, {8'h00, RST_SAT_THR}, "sat thr");
    rchk(OFF_MAX_CNT, {16'h0, RST_MAX_CNT, RST_MAX_CNT}, "max");
    rchk(OFF_WIN_LEN, {16'h0, RST_WIN_LEN}, "win len");
    rchk(8'h3c, 32'h0, "unmapped");
    wr(OFF_SAL_THR, 32'h40);
    wr(OFF_SAT_THR, 32'h10);
    wr(OFF_MAX_CNT, 32'h0101);
    wr(OFF_IRQ_MASK, 32'h7);
    rchk(OFF_MAX_CNT, 32'h0101, "max back");
    $display("test config done");
    // salient, reverse check failing, weak saliency
    for (int c = 0; c < 3; c++) begin
      a = 3'($urandom % 3);
      p = 1'($urandom % 2);
      m = 3'($urandom % 6);
      tb = {6{10'd300}};
      if (c < 2) begin
        tb[a*10 +: 10] = 10'd200;
        tb[((a + 1) % 3)*10 +: 10] = 10'd400;
        tb[((a + 2) % 3)*10 +: 10] = 10'd420;
        tb[(a + 3)*10 +: 10] = (c == 1) ? 10'd500 : (p ? 10'd150 : 10'd250);
      end else begin
        tb[m*10 +: 10] = 10'd240;
        wr(OFF_SAT_THR, 32'hffffff);
      end
      @(posedge clk);
      rise_tbl <= tb;
      exq = '{3'd0, 3'd1, 3'd2};
      if (c < 2) begin
        exq.push_back(a + 3'd3);
      end
      if (c == 0) begin
        exq.push_back(a);
        exq.push_back(a + 3'd3);
      end else begin
        for (int k = 0; k < 6; k++) exq.push_back(3'(k));
      end
      ed = least(tb);
      seq.delete();
      wr(OFF_CTRL, 32'h1);
      wait_idle();
      rd(OFF_STATUS);
      chk(d & 32'h71f, {21'h0, ed, 3'b000, c == 0, 1'b0, c == 2, 2'b10},
          "status");
      chk(seq.size(), exq.size(), "pulses");
      foreach (exq[i]) chk(seq[i], exq[i], "dir");
      rd(OFF_CAPTURE);
      chk_rng(d, tb[exq[$]*10 +: 10] - 3, tb[exq[$]*10 +: 10] + 3,
              "capture");
      chk(irq, 1'b1, "irq done");
      wr(OFF_IRQ_STAT, 32'h7);
      #1 chk(irq, 1'b0, "irq clr");
      $display("test detect %0d done", c);
    end
    // no comparator hit: counter runs out
    no_hit <= 1'b1;
    wr(OFF_CTRL, 32'h1);
    wait_idle();
    rd(OFF_STATUS);
    chk(d & 32'h9, 32'h8, "err");
    chk(drive_en, 1'b0, "drive off");
    rchk(OFF_IRQ_STAT, 32'h2, "irq err");
    chk(irq, 1'b1, "irq on");
    wr(OFF_IRQ_MASK, 32'h0);
    #1 chk(irq, 1'b0, "irq masked");
    wr(OFF_IRQ_STAT, 32'h7);
    wr(OFF_IRQ_MASK, 32'h7);
    rchk(OFF_IRQ_STAT, 32'h0, "irq w1c");
    // abort in mid pulse
    wr(OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    wr(OFF_SAL_THR, 32'h5);
    wr(OFF_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk(drive_en, 1'b0, "abort");
    rd(OFF_STATUS);
    chk(d[0], 1'b0, "abort idle");
    rchk(OFF_SAL_THR, 32'h40, "busy lock");
    no_hit <= 1'b0;
    $display("test error done");
    // method switch with hysteresis
    for (int i = 0; i < 10; i++) begin
      s = (i < 6) ? 16'(sp[i]) : 16'(1700 + $urandom % 260);
      wr(OFF_SPEED, {16'h0, s});
      repeat (3) @(posedge clk);
      me = (s > 16'd1855) ? 1'b1 : ((s <= 16'd1802) ? 1'b0 : me);
      chk(zc_cmp_mode, me, "zc mode");
    end
    rd(OFF_IRQ_STAT);
    chk(d[2], 1'b1, "irq zc");
    // window after a timer edge gates the comparator
    bemf_cmp_pin <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(OFF_SPEED, (i == 0) ? 32'd1856 : 32'd1700);
      repeat (4) @(posedge clk);
      ext_pwm <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pwm <= 1'b0;
      repeat (4) @(posedge clk);
      chk(zc_valid, 1'b0, "before win");
      repeat (100) @(posedge clk);
      chk(zc_valid, i == 0, "in win");
      repeat (200) @(posedge clk);
      chk(zc_valid, 1'b0, "after win");
    end
    $display("test zero cross done");
    report_and_stop();
  end
endmodule
